// file: dv/sep_eeprom_chk.sv
// Port checker for the serial EEPROM controller
`timescale 1ns/1ps
module sep_eeprom_chk #(
    parameter int WRITE_CYCLES = 8
)(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // Bus
    input wire logic scl_pin,
    input wire logic sda_i,
    input wire logic sda_o,
    input wire logic sda_oe,
    // Controls and status
    input wire logic wp_pin,
    input wire logic low_vdd,
    input wire logic write_busy
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    int busy_n;
    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
            busy_n <= 0;
        else if (!write_busy)
            busy_n <= 0;
        else
            busy_n <= busy_n + 1;
    end
    sequence bus_idle;
        scl_pin && sda_i;
    endsequence
    quiet_busy_a: assert property (write_busy |-> !sda_oe)
        else $error("data driven during write cycle");
    oe_low_a: assert property (sda_oe |-> !sda_o)
        else $error("data driven high");
    oe_edge_a: assert property ($changed(sda_oe) |-> !scl_pin)
        else $error("data moved while clock high");
    wp_block_a: assert property ($rose(write_busy) |-> !wp_pin)
        else $error("write cycle while guarded");
    low_cancel_a: assert property ($rose(write_busy) |-> !low_vdd)
        else $error("write cycle at low supply");
    stop_start_a: assert property ($rose(write_busy) |-> bus_idle)
        else $error("write cycle without stop");
    busy_min_a: assert property ($rose(write_busy) |-> write_busy[*8])
        else $error("write cycle too short");
    busy_max_a: assert property (busy_n <= WRITE_CYCLES + 2)
        else $error("write cycle too long");
endmodule

bind sep_eeprom_ctl sep_eeprom_chk #(.WRITE_CYCLES(WRITE_CYCLES)) chk (.ref_clk(ref_clk),
    .sys_rst(sys_rst), .scl_pin(scl_pin), .sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe),
    .wp_pin(wp_pin), .low_vdd(low_vdd), .write_busy(write_busy));

// file: dv/sep_eeprom_ctl_test.sv
// Self-checking bench for the serial EEPROM controller
`timescale 1ns/1ps
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin n_mismatch++; \
    $display("Error at %0t: got %h exp %h", $time, a, e); end end
module sep_eeprom_ctl_test;
    logic ref_clk = 0;
    logic sys_rst = 1;
    logic wp_pin = 0;
    logic low_vdd = 0;
    logic scl_pin, sda_low, sda_o, sda_oe, write_busy, r;
    logic [7:0] q;
    int n_mismatch = 0;
    int comparisons = 0;
    wire sda_line = !(sda_low || (sda_oe && !sda_o));
    sep_eeprom_ctl #(.DEV_CODE(4'h9), .WRITE_CYCLES(200)) dut (.ref_clk(ref_clk),
        .sys_rst(sys_rst), .scl_pin(scl_pin), .sda_i(sda_line), .sda_o(sda_o),
        .sda_oe(sda_oe), .wp_pin(wp_pin), .low_vdd(low_vdd), .write_busy(write_busy));
    sep_master_model m (.ref_clk(ref_clk), .scl_pin(scl_pin), .sda_low(sda_low),
        .sda_line(sda_line));
    initial forever #25 ref_clk = ~ref_clk;
    task automatic hdr(input logic [10:0] a, input logic rd);
        m.start();
        m.xfer({4'h9, a[10:8], rd}, 1'b1, q, r);
    endtask
    task automatic load(input logic [10:0] a);
        hdr(a, 1'b0);
        `CHK(r, 1'b0)
        m.xfer(a[7:0], 1'b1, q, r);
        `CHK(r, 1'b0)
        hdr(a, 1'b1);
        `CHK(r, 1'b0)
    endtask
    task automatic wr(input logic [10:0] a, input logic [7:0] d, input logic nak, input logic bz);
        hdr(a, 1'b0);
        m.xfer(a[7:0], 1'b1, q, r);
        m.xfer(d, 1'b1, q, r);
        `CHK(r, nak)
        m.stop();
        `CHK(write_busy, bz)
        for (int i = 0; i < 10; i++)
        begin
            hdr(a, 1'b1);
            if (i == 0)
                `CHK(r, bz)
            if (r === 1'b0)
                break;
            m.stop();
        end
        `CHK(r, 1'b0)
        m.xfer(8'hff, 1'b1, q, r);
        m.stop();
    endtask
    task automatic rd2(input logic [10:0] a, input logic [7:0] e1, input logic [7:0] e2);
        load(a);
        m.xfer(8'hff, 1'b0, q, r);
        `CHK(q, e1)
        m.xfer(8'hff, 1'b1, q, r);
        `CHK(q, e2)
        m.stop();
    endtask
    task automatic t_wrap();
        wr(11'h7ff, 8'h11, 1'b0, 1'b1);
        wr(11'h000, 8'h22, 1'b0, 1'b1);
        rd2(11'h7ff, 8'h11, 8'h22);
        $display("test wrap done");
    endtask
    task automatic t_guard();
        wp_pin <= 1'b1;
        wr(11'h7ff, 8'h5a, 1'b1, 1'b0);
        wp_pin <= 1'b0;
        rd2(11'h7ff, 8'h11, 8'h22);
        $display("test guard done");
    endtask
    task automatic t_low();
        low_vdd <= 1'b1;
        wr(11'h000, 8'h3c, 1'b0, 1'b0);
        low_vdd <= 1'b0;
        rd2(11'h7ff, 8'h11, 8'h22);
        $display("test low supply done");
    endtask
    task automatic end_sim();
        $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
        if (n_mismatch == 0 && comparisons > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    initial
    begin
        repeat (3) @(posedge ref_clk);
        sys_rst <= 1'b0;
        t_wrap();
        t_guard();
        t_low();
        end_sim();
    end
    initial
    begin
        #1ms;
        n_mismatch++;
        end_sim();
    end
endmodule

// file: dv/sep_master_model.sv
// Bus master model: drives the clock, pulls data low
`timescale 1ns/1ps
module sep_master_model (
    // Clock
    input wire logic ref_clk,
    // Bus
    output logic scl_pin,
    output logic sda_low,
    input wire logic sda_line
);
    initial
    begin
        scl_pin = 1'b1;
        sda_low = 1'b0;
    end
    // Quarter bit; the clock stays low between frames and high only after a stop
    task automatic mv(input logic c, input logic l);
        scl_pin <= c;
        sda_low <= l;
        repeat (2) @(posedge ref_clk);
    endtask
    task automatic bitx(input logic b, output logic s);
        mv(1'b0, !b);
        mv(1'b1, !b);
        s = sda_line;
        mv(1'b1, !b);
        mv(1'b0, !b);
    endtask
    task automatic start();
        mv(1'b0, 1'b0);
        mv(1'b1, 1'b0);
        mv(1'b1, 1'b1);
        mv(1'b0, 1'b1);
    endtask
    task automatic stop();
        mv(1'b0, 1'b1);
        mv(1'b1, 1'b1);
        mv(1'b1, 1'b0);
        mv(1'b1, 1'b0);
    endtask
    // Ninth bit a = 1 releases data
    task automatic xfer(input logic [7:0] d, input logic a, output logic [7:0] q, output logic s);
        for (int i = 7; i >= 0; i--)
            bitx(d[i], q[i]);
        bitx(a, s);
    endtask
endmodule

// file: logic/sep_arr_if.sv
// Link between the bus controller and the array with its page buffer
`timescale 1ns/1ps
interface sep_arr_if;
    import sep_pkg::*;

    logic [ADDR_W-1:0] rd_addr;
    logic [7:0] rd_data;
    logic ld_en;
    logic [PAGE_W-1:0] ld_idx;
    logic [7:0] ld_data;
    logic clr;
    logic prog;
    logic [ADDR_W-PAGE_W-1:0] prog_base;

    modport ctl (
        output rd_addr,
        input rd_data,
        output ld_en,
        output ld_idx,
        output ld_data,
        output clr,
        output prog,
        output prog_base
    );

    modport arr (
        input rd_addr,
        output rd_data,
        input ld_en,
        input ld_idx,
        input ld_data,
        input clr,
        input prog,
        input prog_base
    );
endinterface

// file: logic/sep_eeprom_array.sv
// Memory array with a page buffer that is committed during the write cycle
`timescale 1ns/1ps
module sep_eeprom_array
    import sep_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // Controller side
    sep_arr_if.arr bus
);

    logic [7:0] mem_q [MEM_BYTES];
    logic [7:0] page_q [PAGE_BYTES];
    logic [PAGE_BYTES-1:0] vld_q;
    logic [PAGE_W-1:0] idx_q;

    assign bus.rd_data = mem_q[bus.rd_addr];

    // One page slot per cycle; sixteen cycles cover the page
    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            idx_q <= '0;
        end
        else if (!bus.prog)
        begin
            idx_q <= '0;
        end
        else if (idx_q != PAGE_W'(PAGE_BYTES - 1))
        begin
            idx_q <= idx_q + PAGE_W'(1);
        end
    end

    // Only slots that received data are written back
    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            for (int i = 0; i < MEM_BYTES; i++)
            begin
                mem_q[i] <= ERASED_BYTE;
            end
        end
        else if (bus.prog && vld_q[idx_q])
        begin
            mem_q[{bus.prog_base, idx_q}] <= page_q[idx_q];
        end
    end

    // Later bytes at the same slot overwrite earlier ones
    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            vld_q <= '0;
            for (int i = 0; i < PAGE_BYTES; i++)
            begin
                page_q[i] <= BYTE_RST;
            end
        end
        else if (bus.clr)
        begin
            vld_q <= '0;
        end
        else if (bus.ld_en)
        begin
            page_q[bus.ld_idx] <= bus.ld_data;
            vld_q[bus.ld_idx] <= 1'b1;
        end
    end

endmodule

// file: logic/sep_eeprom_ctl.sv
// Bus-side control of a two-wire serial EEPROM slave
`timescale 1ns/1ps

module sep_eeprom_ctl
    import sep_pkg::*;
#(
    parameter logic [3:0] DEV_CODE = 4'h5, // Arbitrary type code
    parameter int WRITE_CYCLES = WR_CYCLES_DEF
)(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // Two-wire bus, data is open drain
    input wire logic scl_pin,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe,
    // Write guard and supply monitor
    input wire logic wp_pin,
    input wire logic low_vdd,
    // Status
    output logic write_busy
);

    localparam int BUSY_W = $clog2(WRITE_CYCLES + 1);

    // The page commit needs one cycle per slot inside the write cycle
    if (WRITE_CYCLES < PAGE_BYTES + 1)
    begin : g_chk
        $error("WRITE_CYCLES too short for the page commit");
    end

    sep_arr_if arr_if ();

    sep_eeprom_array u_array (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .bus(arr_if.arr)
    );

    // Synchronisers: only stage two is read by logic
    logic [1:0] scl_sy_q;
    logic [1:0] sda_sy_q;
    logic [1:0] wp_sy_q;
    logic [1:0] lv_sy_q;
    logic scl_prev_q;
    logic sda_prev_q;

    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            scl_sy_q <= 2'h3;
            sda_sy_q <= 2'h3;
            wp_sy_q <= 2'h0;
            lv_sy_q <= 2'h0;
            scl_prev_q <= 1'b1;
            sda_prev_q <= 1'b1;
        end
        else
        begin
            scl_sy_q <= {scl_sy_q[0], scl_pin};
            sda_sy_q <= {sda_sy_q[0], sda_i};
            wp_sy_q <= {wp_sy_q[0], wp_pin};
            lv_sy_q <= {lv_sy_q[0], low_vdd};
            scl_prev_q <= scl_sy_q[1];
            sda_prev_q <= sda_sy_q[1];
        end
    end

    logic scl_s;
    logic sda_s;
    logic guard_s;
    logic low_s;
    logic scl_rise;
    logic scl_fall;
    logic start_c;
    logic stop_c;

    assign scl_s = scl_sy_q[1];
    assign sda_s = sda_sy_q[1];
    assign guard_s = wp_sy_q[1];
    assign low_s = lv_sy_q[1];
    assign scl_rise = scl_s & ~scl_prev_q;
    assign scl_fall = ~scl_s & scl_prev_q;
    assign start_c = scl_s & scl_prev_q & sda_prev_q & ~sda_s;
    assign stop_c = scl_s & scl_prev_q & ~sda_prev_q & sda_s;

    // Byte-level state
    sep_state_t st_q;
    logic [3:0] cnt_q;
    logic [7:0] shreg_q;
    logic [7:0] tx_q;
    logic rw_q;
    logic mack_q;
    logic oe_q;
    logic got_q;
    logic busy_q;
    logic [BUSY_W-1:0] busy_cnt_q;
    logic [ADDR_W-1:0] addr_q;

    // States that count clocks of a byte frame
    function automatic logic in_frame(input sep_state_t s);
        return (s == ST_DEV) || (s == ST_WORD) || (s == ST_WDATA) || (s == ST_RDATA);
    endfunction

    logic rise_f;
    logic fall_f;
    logic byte_done;
    logic ack_end;
    logic dev_ok;
    logic wr_go;
    logic busy_done;
    logic send_c;
    logic clr_q;
    logic ld_en_q;
    logic [PAGE_W-1:0] ld_idx_q;
    logic [7:0] ld_data_q;

    // Clock edges only count inside a frame; idle and busy states see none
    assign rise_f = scl_rise & in_frame(st_q);
    assign fall_f = scl_fall & in_frame(st_q);
    // Eight rises seen: the falling edge opens the ninth clock
    assign byte_done = fall_f & (cnt_q == BIT_LAST);
    assign ack_end = fall_f & (cnt_q == BIT_ACKCLK);
    assign dev_ok = (shreg_q[DEV_CODE_HI:DEV_CODE_LO] == DEV_CODE);
    // Guard and low supply both veto the commit, so no busy time follows either
    assign wr_go = stop_c & (st_q == ST_WDATA) & got_q & ~guard_s & ~low_s;
    assign busy_done = busy_q & (busy_cnt_q == '0);
    // A byte goes out after a read address ack or after a master acknowledge
    assign send_c = ack_end & (((st_q == ST_DEV) & rw_q) | ((st_q == ST_RDATA) & ~mack_q));

    // Bit counter within the frame
    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            cnt_q <= BIT_FIRST;
        end
        else if (start_c && !busy_q)
        begin
            cnt_q <= BIT_FIRST;
        end
        else if (ack_end)
        begin
            cnt_q <= BIT_FIRST;
        end
        else if (rise_f && cnt_q != BIT_ACKCLK)
        begin
            cnt_q <= cnt_q + 4'h1;
        end
    end

    // Received bits, sampled while the clock is high
    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            shreg_q <= BYTE_RST;
        end
        else if (rise_f && cnt_q < BIT_LAST)
        begin
            shreg_q <= {shreg_q[6:0], sda_s};
        end
    end

    // Master answer on the ninth clock of a read byte
    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            mack_q <= 1'b1;
        end
        else if (rise_f && cnt_q == BIT_LAST)
        begin
            mack_q <= sda_s;
        end
    end

    // Direction of the current transfer
    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            rw_q <= 1'b0;
        end
        else if (byte_done && st_q == ST_DEV)
        begin
            rw_q <= shreg_q[DIR_BIT];
        end
    end

    // Transfer sequencing
    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            st_q <= ST_IDLE;
        end
        else if (busy_q)
        begin
            st_q <= busy_done ? ST_IDLE : ST_WAIT;
        end
        else if (wr_go)
        begin
            st_q <= ST_WAIT;
        end
        else if (start_c)
        begin
            st_q <= ST_DEV;
        end
        else if (stop_c)
        begin
            st_q <= ST_IDLE;
        end
        else if (byte_done && st_q == ST_DEV && !dev_ok)
        begin
            st_q <= ST_IDLE;
        end
        else if (ack_end)
        begin
            unique case (st_q)
                ST_DEV: st_q <= rw_q ? ST_RDATA : ST_WORD;
                ST_WORD: st_q <= ST_WDATA;
                ST_WDATA: st_q <= ST_WDATA;
                ST_RDATA: st_q <= mack_q ? ST_IDLE : ST_RDATA;
                default: st_q <= ST_IDLE;
            endcase
        end
    end

    // Address counter keeps its value between transfers
    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            addr_q <= ADDR_RST;
        end
        else if (byte_done)
        begin
            unique case (st_q)
                ST_DEV:
                begin
                    if (dev_ok && !shreg_q[DIR_BIT])
                    begin
                        addr_q[ADDR_W-1:WORD_W] <= shreg_q[BLK_HI:BLK_LO];
                    end
                end
                ST_WORD:
                begin
                    addr_q[WORD_W-1:0] <= shreg_q;
                end
                ST_WDATA:
                begin
                    if (!guard_s)
                    begin
                        // No carry into the page number or block bits
                        addr_q[PAGE_W-1:0] <= addr_q[PAGE_W-1:0] + PAGE_W'(1);
                    end
                end
                ST_RDATA:
                begin
                    addr_q <= addr_q + ADDR_W'(1);
                end
                default:
                begin
                    addr_q <= addr_q;
                end
            endcase
        end
    end

    // Data line drive: acknowledge and read bits, changed only while the clock is low
    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            oe_q <= 1'b0;
            tx_q <= BYTE_RST;
        end
        else if (busy_q || start_c || stop_c)
        begin
            oe_q <= 1'b0;
        end
        else if (byte_done)
        begin
            unique case (st_q)
                ST_DEV: oe_q <= dev_ok;
                ST_WORD: oe_q <= 1'b1;
                ST_WDATA: oe_q <= ~guard_s;
                ST_RDATA: oe_q <= 1'b0;
                default: oe_q <= 1'b0;
            endcase
        end
        else if (send_c)
        begin
            tx_q <= arr_if.rd_data;
            oe_q <= ~arr_if.rd_data[WORD_W-1];
        end
        else if (ack_end)
        begin
            oe_q <= 1'b0;
        end
        else if (fall_f && st_q == ST_RDATA && cnt_q != BIT_FIRST)
        begin
            tx_q <= {tx_q[6:0], 1'b0};
            oe_q <= ~tx_q[6];
        end
    end

    // Internal write cycle timer
    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            busy_q <= 1'b0;
            busy_cnt_q <= '0;
        end
        else if (wr_go)
        begin
            busy_q <= 1'b1;
            busy_cnt_q <= BUSY_W'(WRITE_CYCLES - 1);
        end
        else if (busy_done)
        begin
            busy_q <= 1'b0;
        end
        else if (busy_q)
        begin
            busy_cnt_q <= busy_cnt_q - BUSY_W'(1);
        end
    end

    // Page buffer loading; a guarded byte never reaches the buffer
    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            clr_q <= 1'b0;
            ld_en_q <= 1'b0;
            ld_idx_q <= '0;
            ld_data_q <= BYTE_RST;
        end
        else
        begin
            clr_q <= byte_done && st_q == ST_DEV && dev_ok && !shreg_q[DIR_BIT];
            ld_en_q <= byte_done && st_q == ST_WDATA && !guard_s;
            if (byte_done && st_q == ST_WDATA)
            begin
                ld_idx_q <= addr_q[PAGE_W-1:0];
                ld_data_q <= shreg_q;
            end
        end
    end

    // At least one accepted data byte is needed before a stop commits
    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            got_q <= 1'b0;
        end
        else if (start_c && !busy_q)
        begin
            got_q <= 1'b0;
        end
        else if (byte_done && st_q == ST_WDATA && !guard_s)
        begin
            got_q <= 1'b1;
        end
    end

    assign arr_if.rd_addr = addr_q;
    assign arr_if.ld_en = ld_en_q;
    assign arr_if.ld_idx = ld_idx_q;
    assign arr_if.ld_data = ld_data_q;
    assign arr_if.clr = clr_q;
    assign arr_if.prog = busy_q;
    // Block bits sit above the word address in the one counter
    assign arr_if.prog_base = addr_q[ADDR_W-1:PAGE_W];

    // Open drain: the pin only ever pulls low
    assign sda_o = 1'b0;
    assign sda_oe = oe_q;
    assign write_busy = busy_q;

endmodule

// file: logic/sep_pkg.sv
// Shared constants and types for the serial EEPROM bus-side controller
package sep_pkg;

    // Array organisation
    localparam int ADDR_W = 11;
    localparam int WORD_W = 8;
    localparam int BLK_W = 3;
    localparam int PAGE_W = 4;
    localparam int MEM_BYTES = 2048;
    localparam int PAGE_BYTES = 16;
    localparam logic [7:0] ERASED_BYTE = 8'hff;

    // Bit counter positions within one byte frame of nine clocks
    localparam logic [3:0] BIT_FIRST = 4'h0;
    localparam logic [3:0] BIT_LAST = 4'h8;
    localparam logic [3:0] BIT_ACKCLK = 4'h9;

    // Address byte layout: type code, block select, direction
    localparam int DEV_CODE_HI = 7;
    localparam int DEV_CODE_LO = 4;
    localparam int BLK_HI = 3;
    localparam int BLK_LO = 1;
    localparam int DIR_BIT = 0;

    // Internal write cycle
    localparam longint CLK_PERIOD_PS = 50000;
    localparam longint WRITE_TIME_PS = 5000000000;
    localparam int WR_CYCLES_DEF = int'(WRITE_TIME_PS / CLK_PERIOD_PS);

    // Reset values
    localparam logic [ADDR_W-1:0] ADDR_RST = 11'h000;
    localparam logic [7:0] BYTE_RST = 8'h00;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_DEV   = 3'b001,
        ST_WORD  = 3'b010,
        ST_WDATA = 3'b011,
        ST_RDATA = 3'b100,
        ST_WAIT  = 3'b101
    } sep_state_t;

endpackage
